// *** rtl/btc_defines.svh ***
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH
// register byte offsets
`define BTC_CTRL_OFS      8'h00
`define BTC_CMPA_OFS      8'h04
`define BTC_CMPB_OFS      8'h08
`define BTC_STATUS_OFS    8'h0C
`define BTC_INT_STAT_OFS  8'h10
`define BTC_INT_MASK_OFS  8'h14
`define BTC_FIFO_OFS      8'h18
// control fields
`define BTC_CTRL_MODE_LSB 0
`define BTC_CTRL_MODE_MSB 3
`define BTC_CTRL_ARM_BIT  4
`define BTC_CTRL_DEN_BIT  5
`define BTC_CTRL_DVAL_BIT 6
`define BTC_CTRL_BRK_BIT  7
`define BTC_CTRL_TAG_BIT  8
`define BTC_CTRL_RST      9'h000
// status fields
`define BTC_ST_RUN_BIT    0
`define BTC_ST_ASEEN_BIT  1
`define BTC_ST_FULL_BIT   2
`define BTC_ST_EMPTY_BIT  3
`define BTC_ST_CNT_LSB    8
// interrupt fields
`define BTC_INT_TRIG_BIT  0
`define BTC_INT_DONE_BIT  1
`define BTC_INT_RST       2'h0
`define BTC_CMP_RST       16'h0000
// axi responses
`define BTC_RESP_OKAY     2'h0
`define BTC_RESP_SLVERR   2'h2
`endif

// *** rtl/btc_pkg.sv ***
package btc_pkg;
   typedef enum logic [3:0] {
      BTC_A_ONLY       = 4'h0,
      BTC_A_OR_B       = 4'h1,
      BTC_A_THEN_B     = 4'h2,
      BTC_EVENT_B      = 4'h3,
      BTC_A_THEN_EVT_B = 4'h4,
      BTC_A_AND_DATA   = 4'h5,
      BTC_A_AND_NDATA  = 4'h6,
      BTC_INSIDE       = 4'h7,
      BTC_OUTSIDE      = 4'h8
   } btc_mode_t;

   function automatic logic btc_is_store(input logic [3:0] m);
      return (m == BTC_EVENT_B) || (m == BTC_A_THEN_EVT_B);
   endfunction : btc_is_store

   function automatic logic btc_is_full(input logic [3:0] m);
      return (m == BTC_A_AND_DATA) || (m == BTC_A_AND_NDATA);
   endfunction : btc_is_full
endpackage : btc_pkg

// *** rtl/btc_cmp.sv ***
module btc_cmp #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
) (
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] data,
   input  wire logic              rw,
   input  wire logic [ADDR_W-1:0] cmpa,
   input  wire logic [ADDR_W-1:0] cmpb,
   input  wire logic              dir_en,
   input  wire logic              dir_val,
   output logic                   a_match,
   output logic                   b_match,
   output logic                   d_match,
   output logic                   rw_ok,
   output logic                   ge_a,
   output logic                   le_b
);
   assign a_match = (addr == cmpa);
   assign b_match = (addr == cmpb);
   // only the low byte of comparator b meets the data bus
   assign d_match = (data == cmpb[DATA_W-1:0]);
   assign rw_ok   = !dir_en || (rw == dir_val);
   assign ge_a    = (addr >= cmpa);
   assign le_b    = (addr <= cmpb);
endmodule : btc_cmp

// *** rtl/btc_fifo.sv ***
module btc_fifo #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 8,
   parameter int CNT_W  = $clog2(DEPTH+1)
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              flush,
   input  wire logic              push,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              pop,
   output logic [DATA_W-1:0]      rdata,
   output logic                   full,
   output logic                   empty,
   output logic [CNT_W-1:0]       count
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0]  wp_reg;
   logic [PTR_W-1:0]  rp_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic              do_push;
   logic              do_pop;

   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign full    = (cnt_reg == CNT_W'(DEPTH));
   assign empty   = (cnt_reg == '0);
   assign count   = cnt_reg;
   assign rdata   = mem[rp_reg];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp_reg] <= wdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_push) begin
            wp_reg <= (wp_reg == PTR_W'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (do_pop) begin
            rp_reg <= (rp_reg == PTR_W'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
      end
   end
endmodule : btc_fifo

// *** rtl/btc_trigger.sv ***
// Summary of operation
// - a-only mode triggers on address equal a
// - either mode triggers on a or b
// - b match triggers only after earlier a
// - full mode: address a, data b low, direction
// - not-data mode: address a, data differs, direction
// - tag break in full mode uses a only
// - event-b mode captures data on each b
// - after a, every b match captures data
// - storing modes end run when fifo full
// - inside range: a <= address <= b
// - outside range: address < a or > b
`include "btc_defines.svh"
module btc_trigger
   import btc_pkg::*;
#(
   parameter int ADDR_W     = 16,
   parameter int DATA_W     = 8,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              bus_valid,
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic [DATA_W-1:0] bus_data,
   input  wire logic              bus_rw,
   output logic                   trig_pulse,
   output logic                   cpu_force_req,
   output logic                   cpu_tag_req,
   output logic                   run_active,
   output logic                   irq,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam int CNT_W = $clog2(FIFO_DEPTH+1);

   logic [8:0]        ctrl_reg;
   logic [ADDR_W-1:0] cmpa_reg;
   logic [ADDR_W-1:0] cmpb_reg;
   logic [1:0]        int_stat_reg;
   logic [1:0]        int_mask_reg;
   logic              run_reg;
   logic              a_seen_reg;
   logic              trig_reg;
   logic              force_reg;
   logic              tag_reg;
   logic              irq_reg;
   logic [7:0]        awaddr_reg;
   logic              aw_hold_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              w_hold_reg;
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [1:0]        rresp_reg;
   logic [31:0]       rdata_reg;

   logic [3:0]        mode;
   logic              a_m;
   logic              b_m;
   logic              d_m;
   logic              rw_ok;
   logic              ge_a;
   logic              le_b;
   logic              hit;
   logic              live;
   logic              wr_go;
   logic              rd_go;
   logic              arm_go;
   logic              push;
   logic              pop;
   logic [DATA_W-1:0] fifo_rdata;
   logic              fifo_full;
   logic              fifo_empty;
   logic [CNT_W-1:0]  fifo_count;
   logic [1:0]        ev_set;
   logic [31:0]       wmask;

   assign mode = ctrl_reg[`BTC_CTRL_MODE_MSB:`BTC_CTRL_MODE_LSB];
   assign live = run_reg && bus_valid;

   btc_cmp #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_cmp (
      .addr    (bus_addr),
      .data    (bus_data),
      .rw      (bus_rw),
      .cmpa    (cmpa_reg),
      .cmpb    (cmpb_reg),
      .dir_en  (ctrl_reg[`BTC_CTRL_DEN_BIT]),
      .dir_val (ctrl_reg[`BTC_CTRL_DVAL_BIT]),
      .a_match (a_m),
      .b_match (b_m),
      .d_match (d_m),
      .rw_ok   (rw_ok),
      .ge_a    (ge_a),
      .le_b    (le_b)
   );

   always_comb begin
      case (mode)
         BTC_A_ONLY:       hit = a_m;
         BTC_A_OR_B:       hit = a_m || b_m;
         BTC_A_THEN_B:     hit = b_m && a_seen_reg;
         BTC_A_AND_DATA:   hit = a_m && d_m && rw_ok;
         BTC_A_AND_NDATA:  hit = a_m && !d_m && rw_ok;
         BTC_EVENT_B:      hit = b_m;
         BTC_A_THEN_EVT_B: hit = b_m && a_seen_reg;
         BTC_INSIDE:       hit = ge_a && le_b;
         BTC_OUTSIDE:      hit = !ge_a || !le_b;
         default:          hit = 1'b0;
      endcase
   end

   // a full fifo blocks further pushes, so no captured byte is overwritten
   assign push = live && hit && btc_is_store(mode) && !fifo_full;

   btc_fifo #(
      .DATA_W (DATA_W),
      .DEPTH  (FIFO_DEPTH),
      .CNT_W  (CNT_W)
   ) u_fifo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .flush   (arm_go),
      .push    (push),
      .wdata   (bus_data),
      .pop     (pop),
      .rdata   (fifo_rdata),
      .full    (fifo_full),
      .empty   (fifo_empty),
      .count   (fifo_count)
   );

   // a-match memory: set by an earlier cycle only, cleared when re-armed
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         a_seen_reg <= 1'b0;
      end else if (arm_go) begin
         a_seen_reg <= 1'b0;
      end else if (live && a_m) begin
         a_seen_reg <= 1'b1;
      end
   end

   // run control: storing modes stop on a full fifo, the others on the first trigger
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_reg <= 1'b0;
      end else if (arm_go) begin
         run_reg <= 1'b1;
      end else if (run_reg && btc_is_store(mode)) begin
         if (fifo_full) begin
            run_reg <= 1'b0;
         end
      end else if (live && hit) begin
         run_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trig_reg  <= 1'b0;
         force_reg <= 1'b0;
         tag_reg   <= 1'b0;
      end else begin
         trig_reg  <= live && hit;
         force_reg <= live && hit && ctrl_reg[`BTC_CTRL_BRK_BIT] && !ctrl_reg[`BTC_CTRL_TAG_BIT];
         if (live && ctrl_reg[`BTC_CTRL_BRK_BIT] && ctrl_reg[`BTC_CTRL_TAG_BIT]) begin
            // data comparison plays no part in a tag request
            tag_reg <= btc_is_full(mode) ? a_m : hit;
         end else begin
            tag_reg <= 1'b0;
         end
      end
   end

   assign ev_set[`BTC_INT_TRIG_BIT] = live && hit;
   assign ev_set[`BTC_INT_DONE_BIT] = run_reg && btc_is_store(mode) && fifo_full;

   // byte-enable mask for writes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
      end
   end

   assign wr_go  = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign arm_go = wr_go && (awaddr_reg == `BTC_CTRL_OFS) && wstrb_reg[0]
                   && wdata_reg[`BTC_CTRL_ARM_BIT];

   // write address and data are taken independently, in either order
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awready_reg <= 1'b0;
         aw_hold_reg <= 1'b0;
         awaddr_reg  <= 8'h00;
      end else begin
         awready_reg <= 1'b0;
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
         end else if (s_axi_awvalid && awready_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end else if (s_axi_awvalid && !aw_hold_reg && !bvalid_reg) begin
            awready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wready_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else begin
         wready_reg <= 1'b0;
         if (wr_go) begin
            w_hold_reg <= 1'b0;
         end else if (s_axi_wvalid && wready_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (s_axi_wvalid && !w_hold_reg && !bvalid_reg) begin
            wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `BTC_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         if (awaddr_reg == `BTC_CTRL_OFS || awaddr_reg == `BTC_CMPA_OFS ||
             awaddr_reg == `BTC_CMPB_OFS || awaddr_reg == `BTC_INT_STAT_OFS ||
             awaddr_reg == `BTC_INT_MASK_OFS) begin
            bresp_reg <= `BTC_RESP_OKAY;
         end else begin
            bresp_reg <= `BTC_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // configuration registers; the arm bit is a strobe and is not stored
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg     <= `BTC_CTRL_RST;
         cmpa_reg     <= `BTC_CMP_RST;
         cmpb_reg     <= `BTC_CMP_RST;
         int_mask_reg <= `BTC_INT_RST;
      end else if (wr_go) begin
         if (awaddr_reg == `BTC_CTRL_OFS) begin
            ctrl_reg <= 9'((ctrl_reg & ~wmask[8:0]) | (wdata_reg[8:0] & wmask[8:0]))
                        & ~(9'h001 << `BTC_CTRL_ARM_BIT);
         end else if (awaddr_reg == `BTC_CMPA_OFS) begin
            cmpa_reg <= (cmpa_reg & ~wmask[ADDR_W-1:0]) | (wdata_reg[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
         end else if (awaddr_reg == `BTC_CMPB_OFS) begin
            cmpb_reg <= (cmpb_reg & ~wmask[ADDR_W-1:0]) | (wdata_reg[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
         end else if (awaddr_reg == `BTC_INT_MASK_OFS && wstrb_reg[0]) begin
            int_mask_reg <= wdata_reg[1:0];
         end
      end
   end

   // sticky events, write one to clear; a new event wins over the clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_stat_reg <= `BTC_INT_RST;
      end else if (wr_go && awaddr_reg == `BTC_INT_STAT_OFS && wstrb_reg[0]) begin
         int_stat_reg <= (int_stat_reg & ~wdata_reg[1:0]) | ev_set;
      end else begin
         int_stat_reg <= int_stat_reg | ev_set;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(int_stat_reg & int_mask_reg);
      end
   end

   // read channel; a read of the fifo word pops one captured byte
   assign rd_go = s_axi_arvalid && arready_reg;
   assign pop   = rd_go && (s_axi_araddr == `BTC_FIFO_OFS);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= `BTC_RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         arready_reg <= 1'b0;
         if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `BTC_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            if (s_axi_araddr == `BTC_CTRL_OFS) begin
               rdata_reg[8:0] <= ctrl_reg;
            end else if (s_axi_araddr == `BTC_CMPA_OFS) begin
               rdata_reg[ADDR_W-1:0] <= cmpa_reg;
            end else if (s_axi_araddr == `BTC_CMPB_OFS) begin
               rdata_reg[ADDR_W-1:0] <= cmpb_reg;
            end else if (s_axi_araddr == `BTC_STATUS_OFS) begin
               rdata_reg[`BTC_ST_RUN_BIT]   <= run_reg;
               rdata_reg[`BTC_ST_ASEEN_BIT] <= a_seen_reg;
               rdata_reg[`BTC_ST_FULL_BIT]  <= fifo_full;
               rdata_reg[`BTC_ST_EMPTY_BIT] <= fifo_empty;
               rdata_reg[`BTC_ST_CNT_LSB +: CNT_W] <= fifo_count;
            end else if (s_axi_araddr == `BTC_INT_STAT_OFS) begin
               rdata_reg[1:0] <= int_stat_reg;
            end else if (s_axi_araddr == `BTC_INT_MASK_OFS) begin
               rdata_reg[1:0] <= int_mask_reg;
            end else if (s_axi_araddr == `BTC_FIFO_OFS) begin
               rdata_reg[DATA_W-1:0] <= fifo_empty ? '0 : fifo_rdata;
            end else begin
               rresp_reg <= `BTC_RESP_SLVERR;
            end
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end else if (s_axi_arvalid && !rvalid_reg) begin
            arready_reg <= 1'b1;
         end
      end
   end

   assign trig_pulse    = trig_reg;
   assign cpu_force_req = force_reg;
   assign cpu_tag_req   = tag_reg;
   assign run_active    = run_reg;
   assign irq           = irq_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_a_only;
      live && mode == BTC_A_ONLY && bus_addr == cmpa_reg |=> trig_pulse;
   endproperty
   a_a_only: assert property (p_a_only) else $error("a-only match gave no trigger");
   property p_a_or_b;
      live && mode == BTC_A_OR_B && (bus_addr == cmpa_reg || bus_addr == cmpb_reg) |=> trig_pulse;
   endproperty
   a_a_or_b: assert property (p_a_or_b) else $error("either match gave no trigger");
   property p_then_b;
      trig_pulse && $past(mode) == BTC_A_THEN_B |-> $past(a_seen_reg) && $past(bus_addr) == $past(cmpb_reg);
   endproperty
   a_then_b: assert property (p_then_b) else $error("b trigger without earlier a");
   property p_full_data;
      live && mode == BTC_A_AND_DATA && bus_addr == cmpa_reg && bus_data == cmpb_reg[DATA_W-1:0]
      && (!ctrl_reg[`BTC_CTRL_DEN_BIT] || bus_rw == ctrl_reg[`BTC_CTRL_DVAL_BIT]) |=> trig_pulse;
   endproperty
   a_full_data: assert property (p_full_data) else $error("full data match gave no trigger");
   property p_not_data;
      trig_pulse && $past(mode) == BTC_A_AND_NDATA |-> $past(bus_data) != $past(cmpb_reg[DATA_W-1:0]);
   endproperty
   a_not_data: assert property (p_not_data) else $error("not-data trigger on equal data");
   property p_tag_a;
      live && btc_is_full(mode) && ctrl_reg[`BTC_CTRL_BRK_BIT] && ctrl_reg[`BTC_CTRL_TAG_BIT]
      && bus_addr == cmpa_reg |=> cpu_tag_req;
   endproperty
   a_tag_a: assert property (p_tag_a) else $error("tag request missing on a match");
   property p_capture;
      live && mode == BTC_EVENT_B && bus_addr == cmpb_reg && !fifo_full && !arm_go && !pop
      |=> fifo_count == $past(fifo_count) + 1'b1;
   endproperty
   a_capture: assert property (p_capture) else $error("b event did not capture");
   property p_then_capture;
      live && mode == BTC_A_THEN_EVT_B && a_seen_reg && bus_addr == cmpb_reg |=> trig_pulse;
   endproperty
   a_then_capture: assert property (p_then_capture) else $error("b event after a missed");
   property p_full_stop;
      run_reg && btc_is_store(mode) && fifo_full && !arm_go |=> !run_active;
   endproperty
   a_full_stop: assert property (p_full_stop) else $error("run continued with fifo full");
   property p_inside;
      live && mode == BTC_INSIDE && bus_addr >= cmpa_reg && bus_addr <= cmpb_reg |=> trig_pulse;
   endproperty
   a_inside: assert property (p_inside) else $error("inside range missed");
   property p_outside;
      trig_pulse && $past(mode) == BTC_OUTSIDE |-> $past(bus_addr) < $past(cmpa_reg) || $past(bus_addr) > $past(cmpb_reg);
   endproperty
   a_outside: assert property (p_outside) else $error("outside trigger inside range");
   property p_bad_mode;
      mode > 4'h8 |=> !trig_pulse;
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("trigger from unused mode code");

   c_trig: cover property (trig_pulse);
   c_fill: cover property (run_reg && btc_is_store(mode) ##1 fifo_full);
   c_tag:  cover property (cpu_tag_req);
   c_irq:  cover property (irq);
endmodule : btc_trigger

// *** verif/btc_bus_model.sv ***
module btc_bus_model (
   input  wire logic        clk,
   output logic             bus_valid,
   output logic [15:0]      bus_addr,
   output logic [7:0]       bus_data,
   output logic             bus_rw
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      bus_valid = 1'b0;
      bus_addr  = 16'hFFFF;
      bus_data  = 8'hFF;
      bus_rw    = 1'b1;
   end
   // idle lines show the inverse so a stale value never matches
   task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      bus_valid <= 1'b1;
      bus_addr  <= a;
      bus_data  <= d;
      bus_rw    <= w;
      @(posedge clk);
      bus_valid <= 1'b0;
      bus_addr  <= ~a;
      bus_data  <= ~d;
      bus_rw    <= ~w;
   endtask : cycle
endmodule : btc_bus_model

// *** verif/bus_trigger_comparator_logic_tb.sv ***
module bus_trigger_comparator_logic_tb
   import btc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 4;
   logic        clk, sys_rst, bus_valid, bus_rw, trig, frc, tag, run, irq;
   logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [15:0] bus_addr;
   logic [7:0]  bus_data, awa, ara;
   logic [31:0] wd, rdat, rd;
   logic [1:0]  bres, rres, resp;
   logic [15:0] ra [4] = '{16'h0FFF, 16'h1000, 16'h2000, 16'h2001};
   int          errors, tests_run;
   btc_trigger #(.ADDR_W(16), .DATA_W(8), .FIFO_DEPTH(DEPTH)) i_btc_trigger (
      .clk(clk), .sys_rst(sys_rst), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
      .bus_rw(bus_rw), .trig_pulse(trig), .cpu_force_req(frc), .cpu_tag_req(tag), .run_active(run),
      .irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr));
   btc_bus_model i_btc_bus_model (.clk(clk), .bus_valid(bus_valid), .bus_addr(bus_addr),
      .bus_data(bus_data), .bus_rw(bus_rw));
   task automatic finish_test;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (!ok) begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (bv !== 1'b1);
      resp = bres;
      br <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rd = rdat;
      resp = rres;
      rr <= 1'b0;
   endtask : axr
   task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w, e);
      i_btc_bus_model.cycle(a, d, w);
      #1;
      chk(trig === e, "trigger mismatch");
   endtask : cyc
   task automatic setup(input logic [3:0] m, x, input logic [15:0] a, b);
      axw(8'h04, {16'h0, a});
      axw(8'h08, {16'h0, b});
      axw(8'h00, {23'h0, x, 1'b1, m});
   endtask : setup
   task automatic tc(input logic [3:0] m, x, input logic [15:0] a, b, ad, input logic [7:0] d,
                     input logic w, e);
      setup(m, x, a, b);
      cyc(ad, d, w, e);
   endtask : tc
   task automatic seq(input logic [3:0] m, input logic e);
      setup(m, 4'h0, 16'h0100, 16'h0200);
      cyc(16'h0200, 8'h01, 1'b0, 1'b0);
      cyc(16'h0100, 8'h02, 1'b0, 1'b0);
      cyc(16'h0055, 8'h03, 1'b0, 1'b0);
      cyc(16'h0200, 8'h04, 1'b0, 1'b1);
      cyc(16'h0200, 8'h05, 1'b0, e);
   endtask : seq
   task automatic store;
      axw(8'h14, 32'h2);
      setup(BTC_EVENT_B, 4'h0, 16'h0000, 16'h0400);
      cyc(16'h0401, 8'h11, 1'b0, 1'b0);
      for (int i = 0; i < DEPTH; i++) cyc(16'h0400, 8'hC0 + 8'(i), 1'b0, 1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk(run === 1'b0 && irq === 1'b1, "run did not end on full");
      axr(8'h0C);
      chk(rd === 32'h0000_0404, "status after fill");
      for (int i = 0; i < DEPTH; i++) begin
         axr(8'h18);
         chk(rd === {24'h0, 8'hC0 + 8'(i)}, "captured byte");
      end
      axw(8'h10, 32'h3);
      repeat (2) @(posedge clk);
      #1;
      chk(irq === 1'b0, "irq not cleared");
   endtask : store
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #(25 * 20000);
      errors++;
      finish_test();
   end
   initial begin
      {sys_rst, awv, wv, br, arv, rr, awa, ara, wd} = '1;
      {awv, wv, br, arv, rr, awa, ara, wd} = '0;
      errors = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      axr(8'h00);
      chk(rd === 32'h0 && resp === 2'h0, "ctrl reset value");
      axr(8'h1C);
      chk(rd === 32'h0 && resp === 2'h2, "unmapped read");
      axw(8'h1C, 32'h0);
      chk(resp === 2'h2, "unmapped write");
      tc(BTC_A_ONLY, 4'h4, 16'h1234, 16'h5678, 16'h1234, 8'h00, 1'b0, 1'b1);
      chk(frc === 1'b1, "force request");
      axw(8'h14, 32'h1);
      chk(resp === 2'h0, "mask write response");
      #1;
      chk(irq === 1'b1, "irq not raised");
      axw(8'h10, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk(irq === 1'b0, "irq not cleared");
      tc(BTC_A_ONLY, 4'h0, 16'h1234, 16'h5678, 16'h5678, 8'h00, 1'b0, 1'b0);
      tc(BTC_A_OR_B, 4'h0, 16'h1234, 16'h5678, 16'h5678, 8'h00, 1'b0, 1'b1);
      tc(BTC_A_AND_DATA, 4'h3, 16'h1234, 16'hAB78, 16'h1234, 8'h78, 1'b1, 1'b1);
      tc(BTC_A_AND_DATA, 4'h3, 16'h1234, 16'hAB78, 16'h1234, 8'h78, 1'b0, 1'b0);
      tc(BTC_A_AND_NDATA, 4'h0, 16'h1234, 16'h0078, 16'h1234, 8'h79, 1'b0, 1'b1);
      tc(BTC_A_AND_NDATA, 4'h0, 16'h1234, 16'h0078, 16'h1234, 8'h78, 1'b0, 1'b0);
      tc(BTC_A_AND_DATA, 4'hC, 16'h0300, 16'h0011, 16'h0300, 8'h22, 1'b0, 1'b0);
      chk(tag === 1'b1, "tag request");
      for (int k = 0; k < 4; k++) begin
         tc(BTC_INSIDE, 4'h0, 16'h1000, 16'h2000, ra[k], 8'h00, 1'b0, 1'(k == 1 || k == 2));
         tc(BTC_OUTSIDE, 4'h0, 16'h1000, 16'h2000, ra[k], 8'h00, 1'b0, 1'(k == 0 || k == 3));
      end
      tc(4'h9, 4'h0, 16'h1234, 16'h1234, 16'h1234, 8'h00, 1'b0, 1'b0);
      seq(BTC_A_THEN_B, 1'b0);
      seq(BTC_A_THEN_EVT_B, 1'b1);
      store();
      finish_test();
   end
endmodule : bus_trigger_comparator_logic_tb
